// [rtl/fhc_host_top.sv]
/*
 host controller for a 2048 x 9 strobe-driven fifo: software orders a
 reset, write, read or replay over AXI4-Lite; the core drives the pins.
 assumes the fifo pins are asynchronous to clk and the expansion ring,
 when used, is wired on the board.
*/
// Behaviour
// R1: the fifo holds 2048 nine-bit words with separate write and read pointers.
// R2: pointers wrap after 2047; flags follow the pointer difference.
// R3: read strobe falling starts a read unless empty flag is low.
// R4: read data floats unless reading, non-empty and the active reader.
// R5: write strobe falling starts a write unless full flag is low.
// R6: write data is stored on the write strobe rising edge, in sequence.
// R7: a pointer advances only if its flag was high at cycle start.
// R8: reset zeroes pointers, empty flag low, full and half-full high.
// R9: host resets after power up, strobes high around reset rising edge.
// R10: host performs a reset cycle before any other operation.
// R11: chain input and first-load are sampled in reset to pick mode.
// R12: board closes the expansion ring, each chain output to next input.
// R13: the shared pin is chain output in depth, else half-full flag.
// R14: half-full goes low at the write making the count 1025.
// R15: half-full returns high at the read leaving 1024 or fewer.
// R16: full flag falls on the write making the count 2048.
// R17: full flag rises after the first read following full.
// R18: empty flag rises after the first write into an empty fifo.
// R19: empty flag falls on the read that empties the fifo.
// R20: a write begun while full completes after the flag rises.
// R21: a read begun while empty waits; reader holds strobe long enough.
// R22: replay pulse in single mode rewinds only the read pointer.
// R23: in depth mode the chain handshake enables each device's control.
// R24: chain output pulses when the last location is written or read.
// R25: in depth mode first-load is low on the first device only.
// R26: the reader keeps read strobe high during the replay pulse.
// R27: concurrent write and read each move their own pointer.
module fhc_host_top import fhc_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite register bus
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [fhc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [fhc_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // fifo control pins
   output logic reset_n,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic first_load_or_replay_n,
   output logic [fhc_pkg::WORD_W-1:0] write_data_in,
   // fifo status and data pins
   input wire logic [fhc_pkg::WORD_W-1:0] read_data_out,
   input wire logic empty_flag_n,
   input wire logic full_flag_n,
   input wire logic chain_out_or_half_full_n
);
   import fhc_pkg::*;

   fhc_reg_if regs ();
   fhc_state_e state_q;
   logic [TMR_W-1:0] timer_q;
   logic cfgDepth_q, cfgFirst_q, initDone_q;
   logic reqRst_q, reqRt_q, reqWr_q, reqRd_q;
   logic [WORD_W-1:0] wdata_q, rdWord_q;
   logic rdValid_q;
   logic [WORD_W+2:0] pinSync;
   logic [WORD_W-1:0] dataS;
   logic emptyS_n, fullS_n, halfS_n;
   logic [31:0] wv;
   logic cfgWe, cmdWe, wdataWe, rdataRe, idle, tDone;
   logic goRst, goRt, goWr, goRd, busy;

   fhc_axil_slave u_slave (
      .clk(clk),
      .rst(rst),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .regs(regs)
   );

   // ==========================================
   // pin synchronisers
   fhc_sync2 #(.W(WORD_W + 3), .RST_VAL('0)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({read_data_out, empty_flag_n, full_flag_n,
         chain_out_or_half_full_n}),
      .q(pinSync)
   );
   assign dataS = pinSync[WORD_W+2:3];
   assign emptyS_n = pinSync[2];
   assign fullS_n = pinSync[1];
   assign halfS_n = pinSync[0];

   // ==========================================
   // register decode
   assign wv = applyStrb(regs.wrData, regs.wrStrb);
   assign cfgWe = regs.wrEn && (regs.wrAddr == A_CFG);
   assign cmdWe = regs.wrEn && (regs.wrAddr == A_CMD);
   assign wdataWe = regs.wrEn && (regs.wrAddr == A_WDATA) &&
      (regs.wrStrb != 4'h0);
   assign rdataRe = regs.rdEn && (regs.rdAddr == A_RDATA);

   always_comb begin
      regs.rdData = '0;
      case (regs.rdAddr)
         A_CFG: regs.rdData = {30'h0, cfgFirst_q, cfgDepth_q};
         A_WDATA: regs.rdData = {23'h0, wdata_q};
         A_RDATA: regs.rdData = {22'h0, rdValid_q, rdWord_q};
         A_STATUS: regs.rdData = {26'h0, reqRd_q || reqWr_q, !halfS_n,
            !fullS_n, !emptyS_n, initDone_q, busy};
         default: regs.rdData = '0;
      endcase
   end

   // ==========================================
   // launch decisions
   assign idle = (state_q == S_IDLE);
   assign tDone = (timer_q == '0);
   assign busy = !idle;
   assign goRst = idle && reqRst_q;
   // R10: nothing but reset before init
   // R26: replay only with read strobe idle
   assign goRt = idle && !reqRst_q && initDone_q && reqRt_q && !cfgDepth_q;
   // R21: reads only start when not empty, so none waits on a flag
   assign goWr = idle && !reqRst_q && !goRt && initDone_q && reqWr_q &&
      fullS_n;
   assign goRd = idle && !reqRst_q && !goRt && !goWr && initDone_q &&
      reqRd_q && emptyS_n;

   // ==========================================
   // configuration
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgDepth_q <= 1'b0;
         cfgFirst_q <= 1'b0;
      end else if (cfgWe) begin
         cfgDepth_q <= wv[CFG_DEPTH];
         cfgFirst_q <= wv[CFG_FIRST];
      end
   end

   // ==========================================
   // pending orders: a new order beats the launch clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reqRst_q <= 1'b0;
         reqRt_q <= 1'b0;
         reqRd_q <= 1'b0;
      end else begin
         reqRst_q <= (cmdWe && wv[CMD_RESET]) || (reqRst_q && !goRst);
         reqRt_q <= (cmdWe && wv[CMD_REPLAY]) || (reqRt_q && !goRt);
         reqRd_q <= (cmdWe && wv[CMD_READ]) || (reqRd_q && !goRd);
      end
   end

   // a write waiting on a full fifo simply stays pending here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reqWr_q <= 1'b0;
         wdata_q <= '0;
      end else if (wdataWe) begin
         reqWr_q <= 1'b1;
         wdata_q <= wv[WORD_W-1:0];
      end else if (goWr) begin
         reqWr_q <= 1'b0;
      end
   end

   // ==========================================
   // read result
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdWord_q <= '0;
         rdValid_q <= 1'b0;
      end else if (state_q == S_RDLOW && tDone) begin
         rdWord_q <= dataS;
         rdValid_q <= 1'b1;
      end else if (rdataRe) begin
         rdValid_q <= 1'b0;
      end
   end

   // ==========================================
   // pin sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // R9: power-up reset starts by itself
         state_q <= S_RSTLOW;
         timer_q <= TMR_W'(RESET_LOW_CYC - 1);
         reset_n <= 1'b0;
         write_strobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
         write_data_in <= '0;
         initDone_q <= 1'b0;
      end else begin
         if (!tDone) begin
            timer_q <= timer_q - 1'b1;
         end
         case (state_q)
            S_IDLE: begin
               if (goRst) begin
                  state_q <= S_RSTLOW;
                  timer_q <= TMR_W'(RESET_LOW_CYC - 1);
                  reset_n <= 1'b0;
                  initDone_q <= 1'b0;
               end else if (goRt) begin
                  state_q <= S_RTLOW;
                  timer_q <= TMR_W'(REPLAY_LOW_CYC - 1);
               end else if (goWr) begin
                  state_q <= S_WRLOW;
                  timer_q <= TMR_W'(WRITE_LOW_CYC - 1);
                  write_strobe_n <= 1'b0;
                  write_data_in <= wdata_q;
               end else if (goRd) begin
                  state_q <= S_RDLOW;
                  timer_q <= TMR_W'(READ_LOW_CYC - 1);
                  read_strobe_n <= 1'b0;
               end
            end
            S_RSTLOW: if (tDone) begin
               // R9: strobes stay high through the margin
               state_q <= S_RSTHOLD;
               timer_q <= TMR_W'(RESET_MARGIN_CYC - 1);
               reset_n <= 1'b1;
            end
            S_RSTHOLD: if (tDone) begin
               // R10: only now may data orders run
               state_q <= S_RECOVER;
               timer_q <= TMR_W'(SETTLE_CYC - 1);
               initDone_q <= 1'b1;
            end
            S_WRLOW: if (tDone) begin
               state_q <= S_RECOVER;
               timer_q <= TMR_W'(SETTLE_CYC - 1);
               write_strobe_n <= 1'b1;
            end
            S_RDLOW: if (tDone) begin
               state_q <= S_RECOVER;
               timer_q <= TMR_W'(SETTLE_CYC - 1);
               read_strobe_n <= 1'b1;
            end
            S_RTLOW: if (tDone) begin
               state_q <= S_RECOVER;
               timer_q <= TMR_W'(SETTLE_CYC - 1);
            end
            // flags must settle and cross the synchroniser
            S_RECOVER: if (tDone) begin
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // shared first-load / replay pin
   // R12 R25: board ring, strap held steady
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         first_load_or_replay_n <= 1'b1;
      end else if (cfgDepth_q) begin
         first_load_or_replay_n <= !cfgFirst_q;
      end else begin
         first_load_or_replay_n <= !(goRt || (state_q == S_RTLOW && !tDone));
      end
   end

   // ==========================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence rstRise;
      $rose(reset_n);
   endsequence
   sequence strobesHigh2;
      (write_strobe_n && read_strobe_n)[*2];
   endsequence
   sequence rdFall;
      $fell(read_strobe_n);
   endsequence

   marginRst_a: assert property (rstRise |-> strobesHigh2) // R9
      else $error("strobe moved within reset margin");
   rstLow_a: assert property ($fell(reset_n) |-> !reset_n[*2]) // R9
      else $error("reset pulse too short");
   noOpEarly_a: assert property (!initDone_q |-> // R10
      write_strobe_n && read_strobe_n)
      else $error("strobe before reset done");
   rdNotEmpty_a: assert property (rdFall |-> $past(emptyS_n)) // R21
      else $error("read started while empty");
   rdHold_a: assert property (rdFall |-> !read_strobe_n[*4]) // R21
      else $error("read strobe released early");
   replayRd_a: assert property (!first_load_or_replay_n && // R26
      !cfgDepth_q |-> read_strobe_n && reset_n)
      else $error("read strobe low during replay");
   strapFl_a: assert property ($past(cfgDepth_q) && // R25
      $stable(cfgDepth_q) && $stable(cfgFirst_q) |->
      first_load_or_replay_n == !cfgFirst_q)
      else $error("first-load strap wrong in depth mode");
endmodule

// [rtl/fhc_pkg.sv]
/*
 fifo host controller package: timing, register map, states.
 assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package fhc_pkg;
   // ==========================================
   // timing
   localparam int CLK_NS = 40;
   // least times round up, never below one cycle
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      ns2cyc = (c < 1) ? 1 : c;
   endfunction
   localparam int WRITE_LOW_NS = 50;
   // access time plus two synchroniser stages before sampling
   localparam int READ_LOW_NS = 160;
   localparam int RESET_LOW_NS = 80;
   localparam int RESET_MARGIN_NS = 80;
   localparam int REPLAY_LOW_NS = 80;
   localparam int SETTLE_NS = 160;
   localparam int WRITE_LOW_CYC = ns2cyc(WRITE_LOW_NS);
   localparam int READ_LOW_CYC = ns2cyc(READ_LOW_NS);
   localparam int RESET_LOW_CYC = ns2cyc(RESET_LOW_NS);
   localparam int RESET_MARGIN_CYC = ns2cyc(RESET_MARGIN_NS);
   localparam int REPLAY_LOW_CYC = ns2cyc(REPLAY_LOW_NS);
   localparam int SETTLE_CYC = ns2cyc(SETTLE_NS);
   localparam int TMR_W = 4;
   // ==========================================
   // device
   localparam int WORD_W = 9;
   localparam int DEPTH = 2048;
   // ==========================================
   // register map
   localparam int ADDR_W = 5;
   localparam logic [4:0] A_CFG = 5'h00;
   localparam logic [4:0] A_CMD = 5'h04;
   localparam logic [4:0] A_WDATA = 5'h08;
   localparam logic [4:0] A_RDATA = 5'h0c;
   localparam logic [4:0] A_STATUS = 5'h10;
   localparam int CFG_DEPTH = 0;
   localparam int CFG_FIRST = 1;
   localparam int CMD_RESET = 0;
   localparam int CMD_REPLAY = 1;
   localparam int CMD_READ = 2;
   localparam int RD_VALID = 9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   function automatic logic regHit(input logic [4:0] a);
      regHit = (a == A_CFG) || (a == A_CMD) || (a == A_WDATA) ||
         (a == A_RDATA) || (a == A_STATUS);
   endfunction
   function automatic logic [31:0] applyStrb(input logic [31:0] d,
         input logic [3:0] s);
      applyStrb = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction
   // ==========================================
   // sequencer states
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_RSTLOW = 7'h02,
      S_RSTHOLD = 7'h04,
      S_WRLOW = 7'h08,
      S_RDLOW = 7'h10,
      S_RTLOW = 7'h20,
      S_RECOVER = 7'h40
   } fhc_state_e;
endpackage

// [rtl/fhc_reg_if.sv]
/*
 register access carrier between the bus slave and the controller core.
 assumes one clock; strobes are one-cycle pulses.
*/
interface fhc_reg_if;
   logic wrEn;
   logic [4:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic rdEn;
   logic [4:0] rdAddr;
   logic [31:0] rdData;
   modport slave (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
      input rdData);
   modport regs (input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
      output rdData);
endinterface

// [rtl/fhc_sync2.sv]
/*
 two-stage synchroniser for the fifo pins.
 assumes inputs are asynchronous levels; bits are not coherent as a word.
*/
module fhc_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// [rtl/fhc_axil_slave.sv]
/*
 AXI4-Lite slave: turns bus transfers into register strobes.
 assumes one write and one read outstanding; unmapped words get SLVERR.
*/
module fhc_axil_slave import fhc_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [fhc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [fhc_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // register side
   fhc_reg_if.slave regs
);
   logic awHeld_q, wHeld_q, wrGo, arGo;
   logic [4:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;

   // ==========================================
   // write path: address and data in either order
   assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
   assign wrGo = awHeld_q && wHeld_q && !s_axi_bvalid;
   assign regs.wrEn = wrGo && regHit(awAddr_q);
   assign regs.wrAddr = awAddr_q;
   assign regs.wrData = wData_q;
   assign regs.wrStrb = wStrb_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
      end else if (wrGo) begin
         awHeld_q <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wHeld_q <= 1'b0;
         wData_q <= '0;
         wStrb_q <= '0;
      end else if (wrGo) begin
         wHeld_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_q <= 1'b1;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wrGo) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= regHit(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================
   // read path
   assign s_axi_arready = !s_axi_rvalid;
   assign arGo = s_axi_arvalid && s_axi_arready;
   assign regs.rdEn = arGo && regHit(s_axi_araddr);
   assign regs.rdAddr = s_axi_araddr;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (arGo) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= regHit(s_axi_araddr) ? regs.rdData : '0;
         s_axi_rresp <= regHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// [verification/fhc_fifo_model.sv]
/*
 behavioural 2048 x 9 strobe fifo in single-device mode.
 assumes the host keeps both strobes high around reset and replay.
*/
module fhc_fifo_model import fhc_pkg::*; (
   // control pins
   input wire logic reset_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic first_load_or_replay_n,
   input wire logic [fhc_pkg::WORD_W-1:0] write_data_in,
   // status and data pins
   output logic [fhc_pkg::WORD_W-1:0] read_data_out,
   output logic empty_flag_n,
   output logic full_flag_n,
   output logic chain_out_or_half_full_n
);
   // ==========================================
   // storage
   // word array and counts
   // counts: writes begun, writes done, reads begun, reads done
   logic [WORD_W-1:0] mem [DEPTH];
   int c [4] = '{default: 0};
   logic wOk = 0, rOk = 0;
   logic [WORD_W-1:0] lastQ = '0;
   // reset zeroes both sides, chain input grounded
   always @(negedge reset_n) c = '{default: 0};
   always @(negedge write_strobe_n) begin
      wOk = reset_n && full_flag_n;
      if (wOk) c[0]++;
   end
   always @(posedge write_strobe_n) if (wOk && reset_n) begin
      mem[c[1] % DEPTH] = write_data_in;
      c[1]++;
   end
   always @(negedge read_strobe_n) begin
      rOk = reset_n && empty_flag_n;
      if (rOk) c[2]++;
   end
   always @(posedge read_strobe_n) if (rOk) begin
      lastQ = mem[c[3] % DEPTH];
      rOk = 0;
      c[3]++;
   end
   // replay rewinds the read side only
   always @(negedge first_load_or_replay_n) if (reset_n) begin
      c[2] = 0;
      c[3] = 0;
   end
   // ==========================================
   // pins
   // released bus shows the inverse, never a stale word
   assign read_data_out = (!read_strobe_n && rOk) ? mem[c[3] % DEPTH] :
      ~lastQ;
   assign empty_flag_n = c[1] != c[2];
   assign full_flag_n = c[0] - c[3] != DEPTH;
   // shared pin is half-full when chain input grounded
   assign chain_out_or_half_full_n = c[0] - c[3] < 1025;
endmodule

// [verification/tb_top.sv]
/*
 self-checking bench for the fifo host controller.
 assumes the fifo model on the pins and AXI4-Lite from tasks here.
*/
module tb_top import fhc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [31:0] e; logic [31:0] m;} fhc_note_s;
   logic clk = 0, rst = 1;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [4:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, d;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, r;
   logic resetN, wrN, rdN, flrN, emptyN, fullN, hfN;
   logic [WORD_W-1:0] wd, rdq, e;
   logic [WORD_W-1:0] refMem [DEPTH];
   fhc_note_s notes [$];
   fhc_note_s n;
   int fail_count = 0, checked = 0, seed = 28547, cyc = 0, wc = 0, rc = 0;
   always #20 clk = ~clk;
   fhc_host_top i_fhc_host_top (.clk(clk), .rst(rst),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .reset_n(resetN), .write_strobe_n(wrN),
      .read_strobe_n(rdN), .first_load_or_replay_n(flrN),
      .write_data_in(wd), .read_data_out(rdq), .empty_flag_n(emptyN),
      .full_flag_n(fullN), .chain_out_or_half_full_n(hfN));
   fhc_fifo_model i_fhc_fifo_model (.reset_n(resetN), .write_strobe_n(wrN),
      .read_strobe_n(rdN), .first_load_or_replay_n(flrN),
      .write_data_in(wd), .read_data_out(rdq), .empty_flag_n(emptyN),
      .full_flag_n(fullN), .chain_out_or_half_full_n(hfN));
   // ==========================================
   // reporting
   task automatic check(input string nm, input logic [31:0] s, x);
      checked++;
      if (s !== x) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic stop_test;
      if (fail_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // oldest note pairs with each read answer; mask 0 means poll only
   always @(posedge clk) if (rvalid && rready) begin
      n = notes.pop_front();
      if (n.m != '0) check("rdata", rdata & n.m, n.e);
   end
   // ~2100 fifo writes at roughly 11 cycles each
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         fail_count++;
         stop_test();
      end
   end
   // ==========================================
   // bus tasks
   task automatic axw(input logic [4:0] a, input logic [31:0] v);
      logic aw = 1, w = 1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= v;
      while (aw || w) begin
         @(posedge clk);
         if (aw && awready) begin
            aw = 0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 0;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [4:0] a, input logic [31:0] x, m);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      notes.push_back('{x, m});
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic idle;
      do axr(A_STATUS, 0, 0); while (d[5] || d[0]);
   endtask
   task automatic wr(input logic wt);
      logic [WORD_W-1:0] v = WORD_W'($random(seed));
      refMem[wc % DEPTH] = v;
      wc++;
      axw(A_WDATA, {23'h0, v});
      if (wt) idle();
   endtask
   task automatic rdx(input logic [WORD_W-1:0] x);
      axw(A_CMD, 32'h4);
      idle();
      axr(A_RDATA, {22'h0, 1'b1, x}, 32'h3ff);
      rc++;
   endtask
   task automatic replay;
      axw(A_CMD, 32'h2);
      idle();
      rc = 0;
   endtask
   // ==========================================
   // scenarios
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      do axr(A_STATUS, 0, 0); while (!d[1] || d[0]);
      axr(A_STATUS, 32'h06, 32'h3f);
      axw(A_CFG, 32'h0);
      axr(A_CFG, 32'h0, 32'h3);
      // depth mode: host only straps, the ring passes control
      axw(A_CFG, 32'h3);
      @(posedge clk) check("strap", {31'h0, flrN}, 32'h0);
      axw(A_CFG, 32'h1);
      @(posedge clk) check("strap", {31'h0, flrN}, 32'h1);
      axw(A_CFG, 32'h0);
      axw(5'h14, 32'h1);
      check("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      axr(5'h14, 32'h0, 32'hffffffff);
      check("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      // read ordered while empty must wait for a word
      axw(A_CMD, 32'h4);
      axr(A_STATUS, 32'h24, 32'h2c);
      wr(1);
      axr(A_RDATA, {22'h0, 1'b1, refMem[0]}, 32'h3ff);
      rc++;
      axr(A_RDATA, 32'h0, 32'h200);
      axr(A_STATUS, 32'h04, 32'h1c);
      repeat (1024) wr(1);
      axr(A_STATUS, 32'h0, 32'h1c);
      wr(1);
      axr(A_STATUS, 32'h10, 32'h1c);
      rdx(refMem[rc]);
      axr(A_STATUS, 32'h0, 32'h10);
      replay();
      rdx(refMem[rc]);
      rdx(refMem[rc]);
      repeat (1024) wr(1);
      axr(A_STATUS, 32'h18, 32'h1c);
      // a write while full stays pending until a read frees room
      e = refMem[rc];
      wr(0);
      axr(A_STATUS, 32'h28, 32'h28);
      rdx(e);
      axr(A_STATUS, 32'h18, 32'h3d);
      // wrapped writes now own location zero
      replay();
      rdx(refMem[0]);
      // mid-run reset order empties the fifo again
      axw(A_CMD, 32'h1);
      do axr(A_STATUS, 0, 0); while (!d[1] || d[0]);
      axr(A_STATUS, 32'h06, 32'h3f);
      stop_test();
   end
endmodule
